//--- common/vgp_idx_if.sv
// vgp_idx_if: carries one index/data register pair between decoder and bank.
// assumes at most one of the two write strobes per cycle.
interface vgp_idx_if;
  logic idx_we;
  logic dat_we;
  logic [7:0] wdata;
  logic [7:0] idx_q;
  logic [7:0] dat_q;
  modport host (output idx_we, output dat_we, output wdata, input idx_q, input dat_q);
  modport bank (input idx_we, input dat_we, input wdata, output idx_q, output dat_q);
endinterface : vgp_idx_if

//--- common/vgp_pkg.sv
// vgp_pkg: port map, field layout and reset values of the host port decoder.
// assumes a 16-bit host i/o address and 8-bit i/o data.
package vgp_pkg;
  localparam int IO_AW = 16;
  // host i/o ports
  localparam logic [15:0] P_DISPLAY_TIMING_UNIT_INDEX_MONO = 16'h03b4;
  localparam logic [15:0] P_DISPLAY_TIMING_UNIT_DATA_MONO = 16'h03b5;
  localparam logic [15:0] P_COMPAT_MODE_CONTROL_MONO = 16'h03b8;
  localparam logic [15:0] P_LIGHT_PEN_PRESET_MONO = 16'h03b9;
  localparam logic [15:0] P_INPUT_STATUS_ONE_MONO = 16'h03ba;
  localparam logic [15:0] P_LIGHT_PEN_CLEAR_MONO = 16'h03bb;
  localparam logic [15:0] P_LEGACY_GRAPHICS_CARD_REG = 16'h03bf;
  localparam logic [15:0] P_ATTRIBUTE_INDEX_WRITE = 16'h03c0;
  localparam logic [15:0] P_ATTRIBUTE_DATA_READ = 16'h03c1;
  localparam logic [15:0] P_OUTPUT_CONTROL = 16'h03c2;
  localparam logic [15:0] P_SUBSYSTEM_ENABLE = 16'h03c3;
  localparam logic [15:0] P_SEQ_INDEX = 16'h03c4;
  localparam logic [15:0] P_SEQ_DATA = 16'h03c5;
  localparam logic [15:0] P_PIXEL_MASK = 16'h03c6;
  localparam logic [15:0] P_PALETTE_READ_ADDRESS = 16'h03c7;
  localparam logic [15:0] P_PALETTE_WRITE_ADDRESS = 16'h03c8;
  localparam logic [15:0] P_PALETTE_DATA = 16'h03c9;
  localparam logic [15:0] P_FEATURE_CONTROL_READ = 16'h03ca;
  localparam logic [15:0] P_OUTPUT_CONTROL_READ = 16'h03cc;
  localparam logic [15:0] P_GRAPHICS_INDEX = 16'h03ce;
  localparam logic [15:0] P_GRAPHICS_DATA = 16'h03cf;
  localparam logic [15:0] P_DISPLAY_TIMING_UNIT_INDEX_COLOR = 16'h03d4;
  localparam logic [15:0] P_DISPLAY_TIMING_UNIT_DATA_COLOR = 16'h03d5;
  localparam logic [15:0] P_COMPAT_MODE_CONTROL_COLOR = 16'h03d8;
  localparam logic [15:0] P_COMPAT_COLOR_SELECT = 16'h03d9;
  localparam logic [15:0] P_INPUT_STATUS_ONE_COLOR = 16'h03da;
  localparam logic [15:0] P_LIGHT_PEN_CLEAR_COLOR = 16'h03db;
  localparam logic [15:0] P_LIGHT_PEN_PRESET_COLOR = 16'h03dc;
  localparam logic [15:0] P_LEGACY_TERMINAL_MODE_REG = 16'h03de;
  // output control fields
  localparam int OC_VSYNC_NEG = 7;
  localparam int OC_HSYNC_NEG = 6;
  localparam int OC_PAGE_HI = 5;
  localparam int OC_CLK_HI = 3;
  localparam int OC_CLK_LO = 2;
  localparam int OC_VRAM_EN = 1;
  localparam int OC_COLOR_PORTS = 0;
  localparam logic [7:0] OC_WMASK = 8'hef;
  localparam logic [7:0] OC_RST = 8'h00;
  // feature control, subsystem enable, status fields
  localparam int FC_VSYNC_OR = 3;
  localparam logic [7:0] FC_WMASK = 8'h08;
  localparam logic [7:0] FC_RST = 8'h00;
  localparam logic [7:0] SUB_WMASK = 8'h01;
  localparam logic [7:0] SUB_RST = 8'h00;
  localparam int IS0_IRQ = 7;
  localparam int IS0_MON = 4;
  localparam int IS1_DIAG_LO = 4;
  localparam int IS1_VRET = 3;
  localparam int IS1_DISP = 0;
  localparam logic [7:0] COMPAT_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'hff;
  // vertical frame size from the two sync polarity bits
  localparam logic [8:0] LINES_RSVD = 9'h000;
  localparam logic [8:0] LINES_400 = 9'h190;
  localparam logic [8:0] LINES_350 = 9'h15e;
  localparam logic [8:0] LINES_480 = 9'h1e0;
  // straps: set bits are the pulled-down group, latched inverted
  localparam logic [15:0] STRAP_INV = 16'h00f3;
  localparam int STRAP_PANEL_BIT = 15;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // index/data bank depths
  localparam int SEQ_DEPTH = 5;
  localparam int GFX_DEPTH = 9;
  localparam int DISPLAY_TIMING_UNIT_DEPTH = 25;
  localparam int ATTR_DEPTH = 21;
  typedef enum logic [1:0] {ATTR_IDX = 2'b01, ATTR_DAT = 2'b10} vgp_attr_e;
endpackage : vgp_pkg

//--- src/vgp_idx_bank.sv
// vgp_idx_bank: one index register plus the data registers it selects.
// assumes single-cycle write strobes on the clk domain.
module vgp_idx_bank #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // decoder side
  vgp_idx_if.bank bus
);
  localparam int IW = $clog2(DEPTH);
  logic [7:0] idx_r;
  logic [7:0] mem_r [DEPTH];
  wire [IW-1:0] sel = idx_r[IW-1:0];
  wire in_range = int'(idx_r) < DEPTH;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idx_r <= 8'h00;
      for (int i = 0; i < DEPTH; i++) mem_r[i] <= 8'h00;
    end else begin
      if (bus.idx_we) idx_r <= bus.wdata;
      if (bus.dat_we && in_range) mem_r[sel] <= bus.wdata; // [R21]
    end
  end

  // out-of-range indexes read as zero and drop writes
  assign bus.idx_q = idx_r;
  assign bus.dat_q = in_range ? mem_r[sel] : 8'h00; // [R21]

  a_bank_data_lands: assert property (@(posedge clk) disable iff (!nrst)
    bus.dat_we && in_range |=> bus.dat_q == $past(bus.wdata)) // [R21]
    else $error("data write did not reach the selected register");
  a_bank_index_holds: assert property (@(posedge clk) disable iff (!nrst)
    !bus.idx_we |=> idx_r == $past(idx_r)) // [R21]
    else $error("index changed without an index write");
endmodule : vgp_idx_bank

//--- src/vgp_port_decode.sv
// vgp_port_decode: host i/o port decoder and general registers of the display
// controller. assumes io_rd/io_wr are one-cycle strobes from clk-domain logic,
// and that status inputs come from display logic on the same clock.
// Contract
// (R1) latch sixteen strap lines at power-up reset
// (R2) panel strap bit: 0 mono, 1 colour
// (R3) first strap group: pull-up reads as one
// (R4) second strap group: pull-down reads as one
// (R5) address-select bit moves status/feature ports 3Bx/3Dx
// (R6) output control written 3C2, read 3CC
// (R7) input status zero read-only at 3C2
// (R8) status one 3BA/3DA; feature reads 3CA
// (R9) bit 7 picks vertical sync polarity
// (R10) bit 6 picks horizontal sync polarity
// (R11) polarity bits encode 400/350/480 lines
// (R12) bit 5 picks upper page, modes 0-5
// (R13) attribute data written 3C0, read 3C1
// (R14) timing unit index/data at 3B4/3B5 or 3D4/3D5
// (R15) 3C3 enable external on channel-style bus
// (R16) light pen preset at 3B9 or 3DC
// (R17) light pen clear at 3BB or 3DB
// (R18) software writes zero to reserved bits
// (R19) provide legacy compatibility mode/colour/status registers
// (R20) palette strobes low on 3C6-3C9 accesses; the read strobe stays high on 3C7 reads
// (R21) data port reaches register chosen by index
module vgp_port_decode
  import vgp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // host i/o
  input wire logic [IO_AW-1:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic io_rd_hit,
  // board configuration
  input wire logic chan_bus_mode,
  // status from display and palette logic
  input wire logic crt_irq_pend,
  input wire logic monitor_detect,
  input wire logic vretrace,
  input wire logic disp_inactive,
  input wire logic [1:0] diag_bits,
  input wire logic mode_0_5,
  input wire logic lpen_trig,
  input wire logic [7:0] pal_rdata,
  // palette strobes
  output logic palette_read_strobe_n,
  output logic palette_write_strobe_n,
  // output control, feature control and subsystem enable fields
  output logic vsync_neg,
  output logic hsync_neg,
  output logic [8:0] frame_lines,
  output logic frame_size_rsvd,
  output logic page_upper,
  output logic [1:0] clk_sel,
  output logic vram_enable,
  output logic color_ports,
  output logic vsync_or_vde,
  output logic video_enable,
  // compatibility registers
  output logic lpen_latched,
  output logic [7:0] compat_mode_mono,
  output logic [7:0] compat_mode_color,
  output logic [7:0] compat_color_sel,
  output logic [7:0] legacy_graphics,
  output logic [7:0] legacy_terminal,
  // straps
  input wire logic [15:0] strap_memory_lines,
  output logic [15:0] strap_cfg,
  output logic strap_valid,
  output logic panel_color_strap_bit
);
  logic [7:0] oc_r, fc_r, sub_r, rdata_r;
  logic [7:0] mode_mono_r, mode_color_r, color_sel_r, lgfx_r, lterm_r;
  logic lpen_r, rd_hit_r;
  vgp_attr_e attr_r, attr_nxt;

  vgp_idx_if seq_if ();
  vgp_idx_if gfx_if ();
  vgp_idx_if dtu_if ();
  vgp_idx_if attr_if ();

  // port decode; the ? ports follow the address-select bit
  wire [IO_AW-1:0] a = io_addr;
  wire cp = oc_r[OC_COLOR_PORTS];
  wire is_dtu_idx = cp ? a == P_DISPLAY_TIMING_UNIT_INDEX_COLOR : a == P_DISPLAY_TIMING_UNIT_INDEX_MONO; // [R14] [R5]
  wire is_dtu_dat = cp ? a == P_DISPLAY_TIMING_UNIT_DATA_COLOR : a == P_DISPLAY_TIMING_UNIT_DATA_MONO; // [R14] [R5]
  wire is_stat1 = cp ? a == P_INPUT_STATUS_ONE_COLOR : a == P_INPUT_STATUS_ONE_MONO; // [R8] [R5]
  wire is_lp_pre = cp ? a == P_LIGHT_PEN_PRESET_COLOR : a == P_LIGHT_PEN_PRESET_MONO; // [R16]
  wire is_lp_clr = cp ? a == P_LIGHT_PEN_CLEAR_COLOR : a == P_LIGHT_PEN_CLEAR_MONO; // [R17]
  wire is_mode_m = !cp && a == P_COMPAT_MODE_CONTROL_MONO; // [R19]
  wire is_mode_c = cp && a == P_COMPAT_MODE_CONTROL_COLOR; // [R19]
  wire is_csel = cp && a == P_COMPAT_COLOR_SELECT; // [R19]
  wire is_lgfx = a == P_LEGACY_GRAPHICS_CARD_REG;
  wire is_lterm = a == P_LEGACY_TERMINAL_MODE_REG;
  wire is_oc_w = a == P_OUTPUT_CONTROL;
  wire is_oc_r = a == P_OUTPUT_CONTROL_READ;
  wire is_fc_r = a == P_FEATURE_CONTROL_READ;
  // with the channel-style bus the enable register lives off-chip
  wire is_sub = !chan_bus_mode && a == P_SUBSYSTEM_ENABLE; // [R15]
  wire is_attr_i = a == P_ATTRIBUTE_INDEX_WRITE;
  wire is_attr_d = a == P_ATTRIBUTE_DATA_READ;
  wire is_seq_i = a == P_SEQ_INDEX;
  wire is_seq_d = a == P_SEQ_DATA;
  wire is_gfx_i = a == P_GRAPHICS_INDEX;
  wire is_gfx_d = a == P_GRAPHICS_DATA;
  wire is_pal = a >= P_PIXEL_MASK && a <= P_PALETTE_DATA;
  wire is_pal_rs = a == P_PIXEL_MASK || a == P_PALETTE_WRITE_ADDRESS || a == P_PALETTE_DATA;

  // write enables and the status-one read strobe
  wire wr_oc = io_wr && is_oc_w; // [R6]
  wire wr_fc = io_wr && is_stat1;
  wire wr_sub = io_wr && is_sub;
  wire wr_attr = io_wr && is_attr_i;
  wire rd_stat1 = io_rd && is_stat1;

  // palette strobes are level decodes of the host strobes
  assign palette_read_strobe_n = !(io_rd && is_pal_rs); // [R20]
  assign palette_write_strobe_n = !(io_wr && is_pal); // [R20]

  // index/data pairs
  assign seq_if.idx_we = io_wr && is_seq_i;
  assign seq_if.dat_we = io_wr && is_seq_d;
  assign seq_if.wdata = io_wdata;
  assign gfx_if.idx_we = io_wr && is_gfx_i;
  assign gfx_if.dat_we = io_wr && is_gfx_d;
  assign gfx_if.wdata = io_wdata;
  assign dtu_if.idx_we = io_wr && is_dtu_idx; // [R14]
  assign dtu_if.dat_we = io_wr && is_dtu_dat; // [R14]
  assign dtu_if.wdata = io_wdata;
  // 3C0 alternates between index and data on successive writes
  assign attr_if.idx_we = wr_attr && attr_r == ATTR_IDX; // [R13]
  assign attr_if.dat_we = wr_attr && attr_r == ATTR_DAT; // [R13]
  assign attr_if.wdata = io_wdata;

  vgp_idx_bank #(.DEPTH(SEQ_DEPTH)) u_seq (.clk(clk), .nrst(nrst), .bus(seq_if.bank));
  vgp_idx_bank #(.DEPTH(GFX_DEPTH)) u_gfx (.clk(clk), .nrst(nrst), .bus(gfx_if.bank));
  vgp_idx_bank #(.DEPTH(DISPLAY_TIMING_UNIT_DEPTH)) u_dtu (.clk(clk), .nrst(nrst), .bus(dtu_if.bank));
  vgp_idx_bank #(.DEPTH(ATTR_DEPTH)) u_attr (.clk(clk), .nrst(nrst), .bus(attr_if.bank));

  vgp_strap_cap u_strap (
    .clk(clk),
    .nrst(nrst),
    .strap_memory_lines(strap_memory_lines),
    .strap_cfg(strap_cfg),
    .strap_valid(strap_valid)
  );
  assign panel_color_strap_bit = strap_cfg[STRAP_PANEL_BIT]; // [R2]

  // attribute port state: a status-one read forces the index phase
  always_comb begin
    attr_nxt = attr_r;
    if (rd_stat1) begin
      attr_nxt = ATTR_IDX; // [R13]
    end else if (wr_attr) begin
      unique case (attr_r)
        ATTR_IDX: attr_nxt = ATTR_DAT;
        ATTR_DAT: attr_nxt = ATTR_IDX;
        default: attr_nxt = ATTR_IDX;
      endcase
    end
  end

  // status words; reserved bits read zero
  wire [7:0] stat0 = {crt_irq_pend, 2'h0, monitor_detect, 4'h0}; // [R7]
  wire [7:0] stat1 = {2'h0, diag_bits, vretrace, 2'h0, disp_inactive}; // [R8] [R19]

  // read selection; write-only ports fall through to unmapped
  wire rd_mapped = is_oc_w || is_oc_r || is_stat1 || is_fc_r || is_sub ||
                   is_seq_i || is_seq_d || is_gfx_i || is_gfx_d ||
                   is_dtu_idx || is_dtu_dat || is_attr_i || is_attr_d || is_pal;
  wire [7:0] rd_mux =
    is_oc_w ? stat0 : // [R7]
    is_oc_r ? oc_r : // [R6]
    is_stat1 ? stat1 : // [R8]
    is_fc_r ? fc_r : // [R8]
    is_sub ? sub_r :
    is_seq_i ? seq_if.idx_q :
    is_seq_d ? seq_if.dat_q : // [R21]
    is_gfx_i ? gfx_if.idx_q :
    is_gfx_d ? gfx_if.dat_q : // [R21]
    is_dtu_idx ? dtu_if.idx_q :
    is_dtu_dat ? dtu_if.dat_q : // [R14] [R21]
    is_attr_i ? attr_if.idx_q :
    is_attr_d ? attr_if.dat_q : // [R13]
    is_pal ? pal_rdata : UNMAPPED_RDATA;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= UNMAPPED_RDATA;
      rd_hit_r <= 1'b0;
    end else begin
      rd_hit_r <= io_rd && rd_mapped;
      if (io_rd) rdata_r <= rd_mapped ? rd_mux : UNMAPPED_RDATA;
    end
  end
  assign io_rdata = rdata_r;
  assign io_rd_hit = rd_hit_r;

  // general registers; reserved bits are dropped on write so they read zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_r <= OC_RST;
      fc_r <= FC_RST;
      sub_r <= SUB_RST;
      attr_r <= ATTR_IDX;
    end else begin
      if (wr_oc) oc_r <= io_wdata & OC_WMASK; // [R6] [R18]
      if (wr_fc) fc_r <= io_wdata & FC_WMASK; // [R18]
      if (wr_sub) sub_r <= io_wdata & SUB_WMASK;
      attr_r <= attr_nxt;
    end
  end

  // compatibility registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_mono_r <= COMPAT_RST;
      mode_color_r <= COMPAT_RST;
      color_sel_r <= COMPAT_RST;
      lgfx_r <= COMPAT_RST;
      lterm_r <= COMPAT_RST;
    end else begin
      if (io_wr && is_mode_m) mode_mono_r <= io_wdata; // [R19]
      if (io_wr && is_mode_c) mode_color_r <= io_wdata; // [R19]
      if (io_wr && is_csel) color_sel_r <= io_wdata; // [R19]
      if (io_wr && is_lgfx) lgfx_r <= io_wdata;
      if (io_wr && is_lterm) lterm_r <= io_wdata;
    end
  end

  // light pen latch: a trigger in the clearing cycle still sets it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) lpen_r <= 1'b0;
    else if (lpen_trig || (io_wr && is_lp_pre)) lpen_r <= 1'b1; // [R16]
    else if (io_wr && is_lp_clr) lpen_r <= 1'b0; // [R17]
  end

  // field outputs
  wire [1:0] pol = {oc_r[OC_VSYNC_NEG], oc_r[OC_HSYNC_NEG]};
  assign vsync_neg = pol[1]; // [R9]
  assign hsync_neg = pol[0]; // [R10]
  // code 00 is illegal; flagged so the timing unit can hold its previous size
  assign frame_lines = pol == 2'b01 ? LINES_400 :
                       pol == 2'b10 ? LINES_350 :
                       pol == 2'b11 ? LINES_480 : LINES_RSVD; // [R11]
  assign frame_size_rsvd = pol == 2'b00; // [R11]
  assign page_upper = mode_0_5 && oc_r[OC_PAGE_HI]; // [R12]
  assign clk_sel = {oc_r[OC_CLK_HI], oc_r[OC_CLK_LO]};
  assign vram_enable = oc_r[OC_VRAM_EN];
  assign color_ports = cp; // [R5]
  assign vsync_or_vde = fc_r[FC_VSYNC_OR];
  assign video_enable = sub_r[0];
  assign lpen_latched = lpen_r;
  assign compat_mode_mono = mode_mono_r;
  assign compat_mode_color = mode_color_r;
  assign compat_color_sel = color_sel_r;
  assign legacy_graphics = lgfx_r;
  assign legacy_terminal = lterm_r;

  // checks
  sequence s_oc_write_then_read;
    io_wr && a == P_OUTPUT_CONTROL ##1 !io_wr ##1 io_rd && a == P_OUTPUT_CONTROL_READ;
  endsequence

  a_oc_readback: assert property (@(posedge clk) disable iff (!nrst)
    s_oc_write_then_read |=> io_rdata == ($past(io_wdata, 3) & OC_WMASK)) // [R6]
    else $error("output control readback wrong");
  a_stat0_read: assert property (@(posedge clk) disable iff (!nrst)
    io_rd && a == P_OUTPUT_CONTROL |=>
      io_rdata[IS0_MON] == $past(monitor_detect) && io_rdata[IS0_IRQ] == $past(crt_irq_pend))
    // [R7]
    else $error("status zero read wrong");
  a_port_range_mono: assert property (@(posedge clk) disable iff (!nrst)
    !cp && io_rd && (a == P_INPUT_STATUS_ONE_COLOR || a == P_DISPLAY_TIMING_UNIT_DATA_COLOR) |=> !io_rd_hit)
    // [R5] [R8]
    else $error("colour port answered in mono mode");
  a_stat1_read: assert property (@(posedge clk) disable iff (!nrst)
    io_rd && is_stat1 |=> io_rdata[IS1_VRET] == $past(vretrace) &&
      io_rdata[IS1_DISP] == $past(disp_inactive) && io_rd_hit) // [R8]
    else $error("status one read wrong");
  a_sync_pol: assert property (@(posedge clk) disable iff (!nrst)
    wr_oc |=> vsync_neg == $past(io_wdata[OC_VSYNC_NEG]) &&
      hsync_neg == $past(io_wdata[OC_HSYNC_NEG])) // [R9] [R10]
    else $error("sync polarity not taken from output control");
  a_frame_size: assert property (@(posedge clk) disable iff (!nrst)
    (vsync_neg && !hsync_neg |-> frame_lines == LINES_350) and
    (!vsync_neg && hsync_neg |-> frame_lines == LINES_400)) // [R11]
    else $error("frame size decode wrong");
  a_page_select: assert property (@(posedge clk) disable iff (!nrst)
    wr_oc |=> page_upper == (mode_0_5 && $past(io_wdata[OC_PAGE_HI]))) // [R12]
    else $error("page select wrong");
  a_attr_toggle: assert property (@(posedge clk) disable iff (!nrst)
    wr_attr && attr_r == ATTR_IDX ##1 !io_wr && !rd_stat1 ##1 wr_attr |-> attr_if.dat_we) // [R13]
    else $error("second 3c0 write did not reach attribute data");
  a_pal_strobe: assert property (@(posedge clk) disable iff (!nrst)
    io_rd && a == P_PALETTE_READ_ADDRESS |-> palette_read_strobe_n &&
      palette_write_strobe_n == !io_wr) // [R20]
    else $error("palette read strobe on state read");
  a_lpen_clear: assert property (@(posedge clk) disable iff (!nrst)
    io_wr && is_lp_clr && !lpen_trig |=> !lpen_latched) // [R17]
    else $error("light pen latch not cleared");
endmodule : vgp_port_decode

//--- src/vgp_strap_cap.sv
// vgp_strap_cap: catches the strap levels on the memory data lines after reset.
// assumes the straps are static pins, asynchronous to clk.
module vgp_strap_cap
  import vgp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins
  input wire logic [15:0] strap_memory_lines,
  // configuration out
  output logic [15:0] strap_cfg,
  output logic strap_valid
);
  logic [15:0] s1_r, s2_r, s3_r;
  logic [1:0] cnt_r;
  logic done_r;
  wire settled = cnt_r == STRAP_SETTLE && s2_r == s3_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
      s3_r <= 16'h0000;
      cnt_r <= 2'h0;
      done_r <= 1'b0;
      strap_cfg <= 16'h0000;
    end else begin
      s1_r <= strap_memory_lines;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (cnt_r != STRAP_SETTLE) cnt_r <= cnt_r + 2'h1;
      // latched once only; later pin activity is ordinary memory traffic
      if (!done_r && settled) begin
        strap_cfg <= s3_r ^ STRAP_INV; // [R1] [R3] [R4]
        done_r <= 1'b1;
      end
    end
  end
  assign strap_valid = done_r;

  a_strap_frozen: assert property (@(posedge clk) disable iff (!nrst)
    strap_valid |=> $stable(strap_cfg) && strap_valid) // [R1]
    else $error("strap configuration changed after capture");
  a_strap_polarity: assert property (@(posedge clk) disable iff (!nrst)
    $rose(strap_valid) |-> strap_cfg == ($past(s3_r) ^ STRAP_INV)) // [R3] [R4]
    else $error("strap polarity wrong at capture");
endmodule : vgp_strap_cap

//--- tb/vga_io_port_decode_general_regs_tb_top.sv
// bench for the host port decoder; status pins are driven here.
// assumes one clock domain at 25 MHz and an active-low asynchronous reset.
module vga_io_port_decode_general_regs_tb_top
  import vgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] io_addr, straps, pre, clr, oth, strap_cfg;
  logic [7:0] io_wdata, io_rdata, pal_rdata, q, cmm, cmc, ccs, lg, lt;
  logic io_rd, io_wr, io_rd_hit, chan, irq, mon, vret, dis, mode05, lpen, rs, ws, hit;
  logic prs, pws, vsn, hsn, rsvd, page, video_en, lpen_q, strap_valid, panel;
  logic [1:0] diag;
  logic [8:0] lines;
  logic [4:0] ocl;
  int n_fail = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  vgp_host_model h (.clk(clk), .io_addr(io_addr), .io_rd(io_rd), .io_wr(io_wr),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_hit(io_rd_hit),
    .palette_read_strobe_n(prs), .palette_write_strobe_n(pws));
  vgp_port_decode dut_u (.clk(clk), .nrst(nrst), .io_addr(io_addr), .io_rd(io_rd),
    .io_wr(io_wr), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rd_hit(io_rd_hit),
    .chan_bus_mode(chan), .crt_irq_pend(irq), .monitor_detect(mon), .vretrace(vret),
    .disp_inactive(dis), .diag_bits(diag), .mode_0_5(mode05), .lpen_trig(lpen),
    .pal_rdata(pal_rdata), .palette_read_strobe_n(prs), .palette_write_strobe_n(pws),
    .vsync_neg(vsn), .hsync_neg(hsn), .frame_lines(lines), .frame_size_rsvd(rsvd),
    .page_upper(page), .clk_sel(ocl[3:2]), .vram_enable(ocl[1]), .color_ports(ocl[0]),
    .vsync_or_vde(ocl[4]),
    .video_enable(video_en), .lpen_latched(lpen_q), .compat_mode_mono(cmm),
    .compat_mode_color(cmc), .compat_color_sel(ccs), .legacy_graphics(lg),
    .legacy_terminal(lt), .strap_memory_lines(straps), .strap_cfg(strap_cfg),
    .strap_valid(strap_valid), .panel_color_strap_bit(panel));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    h.rd(a, q, hit, rs);
    chk(16'(q), 16'(e), "read data");
    chk(16'(hit), 16'h0001, "read hit");
  endtask : rdc
  task automatic rdn(input logic [15:0] a);
    h.rd(a, q, hit, rs);
    chk(16'(q), 16'h00ff, "refused");
    chk(16'(hit), 16'h0000, "refused hit");
  endtask : rdn
  task automatic t_straps;
    for (int i = 0; i < 10 && strap_valid !== 1'b1; i++) @(negedge clk);
    chk(16'(strap_valid), 16'h0001, "strap valid");
    chk(strap_cfg, straps ^ 16'h00f3, "strap cfg");
    chk(16'(panel), 16'(straps[15]), "panel");
    chk(16'(rsvd), 16'h0001, "reset size");
    rdc(P_OUTPUT_CONTROL_READ, 8'h00);
    $display("end straps");
  endtask : t_straps
  task automatic t_outctl;
    logic [7:0] d;
    logic [8:0] fl;
    for (int k = 1; k < 4; k++) begin
      d = {k[1:0], 6'h2b}; // reserved bit 4 kept zero
      fl = (k == 1) ? 9'h190 : (k == 2) ? 9'h15e : 9'h1e0;
      mode05 = k[0];
      h.wr(P_OUTPUT_CONTROL, d, ws);
      chk(16'(vsn), 16'(k[1]), "vsync pol");
      chk(16'(hsn), 16'(k[0]), "hsync pol");
      chk(16'(lines), 16'(fl), "frame lines");
      chk(16'(rsvd), 16'(k == 0), "size rsvd");
      chk(16'(page), 16'(k[0]), "page");
      chk(16'(ocl), 16'(d[3:0]), "oc low");
      rdc(P_OUTPUT_CONTROL_READ, d);
    end
    $display("end outctl");
  endtask : t_outctl
  task automatic t_status;
    h.wr(P_OUTPUT_CONTROL, 8'h00, ws);
    irq = 1'b1;
    mon = 1'b1;
    diag = 2'b10;
    vret = 1'b1;
    rdc(P_OUTPUT_CONTROL, 8'h90);
    rdc(P_INPUT_STATUS_ONE_MONO, 8'h28);
    rdn(P_INPUT_STATUS_ONE_COLOR);
    h.wr(P_INPUT_STATUS_ONE_MONO, 8'h08, ws);
    rdc(P_FEATURE_CONTROL_READ, 8'h08);
    chk(16'(ocl[4]), 16'h0001, "fc bit 3");
    h.wr(P_OUTPUT_CONTROL, 8'h01, ws);
    dis = 1'b1;
    h.wr(P_INPUT_STATUS_ONE_MONO, 8'h00, ws);
    rdc(P_FEATURE_CONTROL_READ, 8'h08);
    rdc(P_INPUT_STATUS_ONE_COLOR, 8'h29);
    h.wr(P_INPUT_STATUS_ONE_COLOR, 8'h00, ws);
    rdc(P_FEATURE_CONTROL_READ, 8'h00);
    $display("end status");
  endtask : t_status
  task automatic pair(input logic [15:0] ia, input logic [15:0] da);
    h.wr(ia, 8'h02, ws);
    h.wr(da, 8'h05, ws);
    h.wr(ia, 8'h03, ws);
    h.wr(da, 8'h1c, ws);
    h.wr(ia, 8'h02, ws);
    rdc(da, 8'h05);
    rdc(ia, 8'h02);
  endtask : pair
  task automatic t_index;
    pair(P_DISPLAY_TIMING_UNIT_INDEX_COLOR, P_DISPLAY_TIMING_UNIT_DATA_COLOR);
    rdn(P_DISPLAY_TIMING_UNIT_INDEX_MONO);
    h.wr(P_OUTPUT_CONTROL, 8'h00, ws);
    pair(P_DISPLAY_TIMING_UNIT_INDEX_MONO, P_DISPLAY_TIMING_UNIT_DATA_MONO);
    rdn(P_DISPLAY_TIMING_UNIT_DATA_COLOR);
    pair(P_SEQ_INDEX, P_SEQ_DATA);
    pair(P_GRAPHICS_INDEX, P_GRAPHICS_DATA);
    h.rd(P_INPUT_STATUS_ONE_MONO, q, hit, rs);
    h.wr(P_ATTRIBUTE_INDEX_WRITE, 8'h01, ws);
    h.wr(P_ATTRIBUTE_INDEX_WRITE, 8'h37, ws);
    h.wr(P_ATTRIBUTE_INDEX_WRITE, 8'h02, ws);
    h.wr(P_ATTRIBUTE_INDEX_WRITE, 8'h18, ws);
    h.wr(P_ATTRIBUTE_INDEX_WRITE, 8'h01, ws);
    rdc(P_ATTRIBUTE_DATA_READ, 8'h37);
    $display("end index");
  endtask : t_index
  task automatic t_pal;
    pal_rdata = 8'h5c;
    for (logic [15:0] a = P_PIXEL_MASK; a <= P_PALETTE_DATA; a++) begin
      h.rd(a, q, hit, rs);
      chk(16'(rs), 16'(a == P_PALETTE_READ_ADDRESS), "read strobe");
      chk(16'(q), 16'h005c, "pal data");
      h.wr(a, 8'h00, ws);
      chk(16'(ws), 16'h0000, "write strobe");
    end
    h.rd(P_OUTPUT_CONTROL_READ, q, hit, rs);
    h.wr(P_OUTPUT_CONTROL, 8'h00, ws);
    chk(16'({rs, ws}), 16'h0003, "idle");
    $display("end palette");
  endtask : t_pal
  task automatic t_lpen;
    for (int m = 0; m < 2; m++) begin
      pre = m ? P_LIGHT_PEN_PRESET_COLOR : P_LIGHT_PEN_PRESET_MONO;
      clr = m ? P_LIGHT_PEN_CLEAR_COLOR : P_LIGHT_PEN_CLEAR_MONO;
      oth = m ? P_LIGHT_PEN_PRESET_MONO : P_LIGHT_PEN_PRESET_COLOR;
      h.wr(P_OUTPUT_CONTROL, 8'(m), ws);
      h.wr(pre, 8'h00, ws);
      chk(16'(lpen_q), 16'h0001, "lpen preset");
      h.wr(clr, 8'h00, ws);
      chk(16'(lpen_q), 16'h0000, "lpen clear");
      h.wr(oth, 8'h00, ws);
      chk(16'(lpen_q), 16'h0000, "lpen other");
    end
    $display("end lpen");
  endtask : t_lpen
  task automatic t_compat;
    h.wr(P_COMPAT_MODE_CONTROL_COLOR, 8'h2d, ws);
    h.wr(P_COMPAT_COLOR_SELECT, 8'h30, ws);
    h.wr(P_LEGACY_TERMINAL_MODE_REG, 8'h41, ws);
    h.wr(P_COMPAT_MODE_CONTROL_MONO, 8'h29, ws);
    chk({cmc, ccs}, 16'h2d30, "colour");
    chk({lt, cmm}, 16'h4100, "terminal");
    h.wr(P_OUTPUT_CONTROL, 8'h00, ws);
    h.wr(P_COMPAT_MODE_CONTROL_MONO, 8'h29, ws);
    h.wr(P_LEGACY_GRAPHICS_CARD_REG, 8'h03, ws);
    chk({cmm, lg}, 16'h2903, "mono");
    h.wr(P_SUBSYSTEM_ENABLE, 8'h01, ws);
    rdc(P_SUBSYSTEM_ENABLE, 8'h01);
    chan = 1'b1;
    rdn(P_SUBSYSTEM_ENABLE);
    h.wr(P_SUBSYSTEM_ENABLE, 8'h00, ws);
    chk(16'(video_en), 16'h0001, "3c3 ext");
    rdn(16'h0300);
    $display("end compat");
  endtask : t_compat
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  initial begin
    #200000;
    n_fail++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial begin
    {chan, irq, mon, vret, dis, mode05, lpen} = 7'h00;
    diag = 2'b00;
    pal_rdata = 8'h00;
    straps = 16'h5ac3;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    t_straps();
    t_outctl();
    t_status();
    t_index();
    t_pal();
    t_lpen();
    t_compat();
    tally_and_finish();
  end
endmodule : vga_io_port_decode_general_regs_tb_top

//--- tb/vgp_host_model.sv
// vgp_host_model: host processor side of the port decoder, one-cycle i/o strobes.
// assumes rising-edge sampling; requests change on the falling edge.
module vgp_host_model (
  // clock
  input wire logic clk,
  // host i/o
  output logic [15:0] io_addr,
  output logic io_rd,
  output logic io_wr,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rd_hit,
  // palette strobes, sampled just after a request starts
  input wire logic palette_read_strobe_n,
  input wire logic palette_write_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    io_addr = 16'h0000;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_wdata = 8'h00;
  end
  // released lines show the inverse, so stale values never pass as held
  task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic ws);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    #1 ws = palette_write_strobe_n;
    @(negedge clk);
    io_wr = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [7:0] q, output logic hit,
                    output logic rs);
    @(negedge clk);
    io_addr = a;
    io_rd = 1'b1;
    #1 rs = palette_read_strobe_n;
    @(negedge clk);
    q = io_rdata;
    hit = io_rd_hit;
    io_rd = 1'b0;
    io_addr = ~a;
  endtask : rd
endmodule : vgp_host_model
